// File: verilog/bib_consts.svh
// constants for the bus info block registers
`ifndef BIB_CONSTS_SVH
`define BIB_CONSTS_SVH

// ---------------------------------------------
// offsets
// ---------------------------------------------
`define BIB_OPT_OFFSET        8'h20
`define BIB_UID_HI_OFFSET     8'h24
`define BIB_CTRL_OFFSET       8'h40
`define BIB_STAT_OFFSET       8'h44

// ---------------------------------------------
// bus options fields and control register link enable bit
// ---------------------------------------------
`define BIB_PMC_BIT           27
`define BIB_ACC_LSB           16
`define BIB_ACC_MSB           23
`define BIB_REC_LSB           12
`define BIB_REC_MSB           15
`define BIB_GEN_LSB           6
`define BIB_GEN_MSB           7
`define BIB_SPD_MSB           2
`define BIB_LINK_EN_BIT       17
`define BIB_OPT_RESET         32'h0000a002
`define BIB_REC_RESET         4'ha
`define BIB_SPD_VALUE         3'h2
`define BIB_OPT_WMASK         32'hf8fff0c0

// ---------------------------------------------
// serial rom timing
// ---------------------------------------------
`define BIB_ROM_BIT_NS        40
`define BIB_CLK_NS            4
`define BIB_ROM_HALF_CYC      ((`BIB_ROM_BIT_NS + `BIB_CLK_NS - 1) / `BIB_CLK_NS)

`endif

// File: verilog/bib_pkg.sv
// types for the bus info block registers
package bib_pkg;
    typedef enum logic [1:0] {
        rom_idle_type_s  = 2'b00,
        rom_shift_type_s = 2'b01,
        rom_done_type_s  = 2'b10
    } rom_state_type;
endpackage

// File: verilog/bib_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bib_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic din,
    output logic      dout
);
    logic meta_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= 1'b0;
            dout    <= 1'b0;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule

// File: verilog/bib_rom_loader.sv
// serial rom reader for the upper unique-id quadlet
`timescale 1ns/1ps
`include "bib_consts.svh"
module bib_rom_loader
    import bib_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic        rom_data,
    output logic             rom_clk,
    output logic             load_valid,
    output logic [31:0]      load_data
);
    rom_state_type state_ff;
    logic [7:0]    div_ff;
    logic [5:0]    cnt_ff;
    logic [31:0]   shift_ff;

    // ---------------------------------------------
    // shift sequencer
    // ---------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff   <= rom_idle_type_s;
            div_ff     <= 8'h00;
            cnt_ff     <= 6'h00;
            shift_ff   <= 32'h00000000;
            rom_clk    <= 1'b0;
            load_valid <= 1'b0;
            load_data  <= 32'h00000000;
        end else begin
            load_valid <= 1'b0;
            case (state_ff)
                rom_idle_type_s: begin
                    if (start) begin
                        state_ff <= rom_shift_type_s;
                        cnt_ff   <= 6'h00;
                        div_ff   <= 8'h00;
                    end
                end
                rom_shift_type_s: begin
                    if (div_ff == 8'(`BIB_ROM_HALF_CYC - 1)) begin
                        div_ff  <= 8'h00;
                        rom_clk <= ~rom_clk;
                        // sample on rising rom clock
                        if (!rom_clk) begin
                            shift_ff <= {shift_ff[30:0], rom_data};
                            cnt_ff   <= cnt_ff + 6'h01;
                        end else if (cnt_ff == 6'h20) begin
                            state_ff <= rom_done_type_s;
                        end
                    end else begin
                        div_ff <= div_ff + 8'h01;
                    end
                end
                rom_done_type_s: begin
                    load_valid <= 1'b1;
                    load_data  <= shift_ff;
                    state_ff   <= rom_idle_type_s;
                end
                default: state_ff <= rom_idle_type_s;
            endcase
        end
    end
endmodule

// File: verilog/bib_regs.sv
// apb register bank for bus options and upper unique-id quadlet
//
// What this block does
// - reserved bits 26:24, 11:8 and 5:3 of bus options always read as zero.
// - bits 23:16 hold the read/write cycle-master clock accuracy in ppm.
// - bits 15:12 hold the max block size code, byte count two to the code plus one.
// - hard reset sets the size code to the 2048 byte value, soft reset keeps it.
// - software writes to the size code become the receive limit used afterwards.
// - a block write longer than the limit may be answered with a type error.
// - the 2-bit generation counter in bits 7:6 advances on a rom change and is writable.
// - link speed bits 2:0 read the constant 010.
// - hard reset clears the upper unique-id quadlet at 24h to zero.
// - with a serial rom present the quadlet is loaded from it after each host-bus reset.
// - the quadlet never changes on host writes, rom or not.
// - vendor identifier sits in 31:8 and upper chip identifier in 7:0, read only.
// - bus options sits at 20h and resets to 0000a002h.
`timescale 1ns/1ps
`include "bib_consts.svh"
module bib_regs
    import bib_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        soft_resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        host_bus_reset,
    input  wire logic        rom_present,
    input  wire logic        rom_data,
    output logic             rom_clk,
    input  wire logic        rom_changed,
    input  wire logic        blk_wr_valid,
    input  wire logic [15:0] blk_wr_len,
    output logic             blk_wr_type_err,
    output logic [3:0]       max_rec_code,
    output logic             link_enable_bit
);
    logic [31:0] opt_ff;
    logic [31:0] uid_ff;
    logic        link_en_ff;
    logic        uid_loaded_ff;
    logic        hbr_d_ff;
    logic        err_ff;
    logic        rom_present_s;
    logic        rom_data_s;
    logic        soft_resetn_s;
    logic        soft_rst_s;
    logic        hbr_s;
    logic        rom_start;
    logic        load_valid;
    logic [31:0] load_data;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] wmask;
    logic [31:0] nxt_opt;
    logic [31:0] nxt_rdata;
    logic [16:0] max_bytes;

    // ---------------------------------------------
    // pin synchronisers
    // ---------------------------------------------
    bib_sync u_sync_present (.pclk(pclk), .presetn(presetn), .din(rom_present),
                             .dout(rom_present_s));
    bib_sync u_sync_data (.pclk(pclk), .presetn(presetn), .din(rom_data),
                          .dout(rom_data_s));
    bib_sync u_sync_soft (.pclk(pclk), .presetn(presetn), .din(~soft_resetn),
                          .dout(soft_rst_s));
    // inverted so a hard reset never looks like a soft reset
    assign soft_resetn_s = ~soft_rst_s;
    bib_sync u_sync_hbr (.pclk(pclk), .presetn(presetn), .din(host_bus_reset),
                         .dout(hbr_s));

    // ---------------------------------------------
    // apb decode
    // ---------------------------------------------
    // zero wait states keep the bus simple
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;

    always_comb begin
        wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    end

    // ---------------------------------------------
    // bus options register
    // ---------------------------------------------
    always_comb begin
        nxt_opt = opt_ff;
        if (wr_en && paddr == `BIB_OPT_OFFSET) begin
            nxt_opt = (opt_ff & ~(wmask & `BIB_OPT_WMASK))
                    | (pwdata & wmask & `BIB_OPT_WMASK);
        end
        if (rom_changed) begin
            nxt_opt[`BIB_GEN_MSB:`BIB_GEN_LSB] = opt_ff[`BIB_GEN_MSB:`BIB_GEN_LSB] + 2'h1;
        end
        nxt_opt[26:24] = 3'h0;
        nxt_opt[11:8]  = 4'h0;
        nxt_opt[5:3]   = 3'h0;
        nxt_opt[`BIB_SPD_MSB:0] = `BIB_SPD_VALUE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_ff <= `BIB_OPT_RESET;
        end else if (!soft_resetn_s) begin
            opt_ff <= (`BIB_OPT_RESET & ~32'h0000f000) | (opt_ff & 32'h0000f000);
        end else begin
            opt_ff <= nxt_opt;
        end
    end

    // ---------------------------------------------
    // link enable control
    // ---------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_en_ff <= 1'b0;
        end else if (!soft_resetn_s) begin
            link_en_ff <= 1'b0;
        end else if (wr_en && paddr == `BIB_CTRL_OFFSET && pstrb[2]) begin
            link_en_ff <= pwdata[`BIB_LINK_EN_BIT];
        end
    end
    assign link_enable_bit = link_en_ff;

    // ---------------------------------------------
    // upper unique-id quadlet
    // ---------------------------------------------
    assign rom_start = hbr_s && !hbr_d_ff && rom_present_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hbr_d_ff      <= 1'b0;
            uid_ff        <= 32'h00000000;
            uid_loaded_ff <= 1'b0;
        end else begin
            hbr_d_ff <= hbr_s;
            if (load_valid) begin
                uid_ff        <= load_data;
                uid_loaded_ff <= 1'b1;
            end
        end
    end

    bib_rom_loader u_rom (
        .pclk       (pclk),
        .presetn    (presetn),
        .start      (rom_start),
        .rom_data   (rom_data_s),
        .rom_clk    (rom_clk),
        .load_valid (load_valid),
        .load_data  (load_data)
    );

    // ---------------------------------------------
    // block write length check
    // ---------------------------------------------
    // bytes are two to code plus one
    assign max_bytes    = 17'h00001 << ({1'b0, opt_ff[`BIB_REC_MSB:`BIB_REC_LSB]} + 5'h01);
    assign max_rec_code = opt_ff[`BIB_REC_MSB:`BIB_REC_LSB];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_ff <= 1'b0;
        end else begin
            err_ff <= blk_wr_valid && ({1'b0, blk_wr_len} > max_bytes);
        end
    end
    assign blk_wr_type_err = err_ff;

    // ---------------------------------------------
    // read data
    // ---------------------------------------------
    always_comb begin
        case (paddr)
            `BIB_OPT_OFFSET:    nxt_rdata = opt_ff;
            `BIB_UID_HI_OFFSET: nxt_rdata = uid_ff;
            `BIB_CTRL_OFFSET:   nxt_rdata = {14'h0000, link_en_ff, 17'h00000};
            `BIB_STAT_OFFSET:   nxt_rdata = {30'h00000000, uid_loaded_ff, rom_present_s};
            default:            nxt_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            prdata <= nxt_rdata;
        end
    end

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        (opt_ff[26:24] == 3'h0) && (opt_ff[11:8] == 4'h0) && (opt_ff[5:3] == 3'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_speed_const;
        @(posedge pclk) disable iff (!presetn)
        opt_ff[2:0] == 3'h2;
    endproperty
    a_speed_const: assert property (p_speed_const) else $error("link speed wrong");

    property p_acc_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == 8'h20 && pstrb[2] && soft_resetn_s) |=> opt_ff[23:16] == $past(pwdata[23:16]);
    endproperty
    a_acc_write: assert property (p_acc_write) else $error("accuracy not written");

    property p_rec_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == 8'h20 && pstrb[1] && soft_resetn_s)
            |=> max_rec_code == $past(pwdata[15:12]);
    endproperty
    a_rec_write: assert property (p_rec_write) else $error("size code not written");

    property p_soft_keep;
        @(posedge pclk) disable iff (!presetn)
        !soft_resetn_s |=> max_rec_code == $past(max_rec_code);
    endproperty
    a_soft_keep: assert property (p_soft_keep) else $error("soft reset changed size code");

    property p_uid_ro;
        @(posedge pclk) disable iff (!presetn)
        !load_valid |=> $stable(uid_ff);
    endproperty
    a_uid_ro: assert property (p_uid_ro) else $error("unique id changed");

    property p_gen_inc;
        @(posedge pclk) disable iff (!presetn)
        (rom_changed && soft_resetn_s) |=> opt_ff[7:6] == $past(opt_ff[7:6]) + 2'h1;
    endproperty
    a_gen_inc: assert property (p_gen_inc) else $error("generation not advanced");

    property p_len_err;
        @(posedge pclk) disable iff (!presetn)
        (blk_wr_valid && blk_wr_len == 16'h0800 && max_rec_code == 4'ha) |=> !blk_wr_type_err;
    endproperty
    a_len_err: assert property (p_len_err) else $error("false length error");

    property p_ro_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == 8'h24) |=> $stable(uid_ff) || $past(load_valid);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("write hit read-only quadlet");

    property p_len_over;
        @(posedge pclk) disable iff (!presetn)
        (blk_wr_valid && blk_wr_len == 16'h0801 && max_rec_code == 4'ha) |=> blk_wr_type_err;
    endproperty
    a_len_over: assert property (p_len_over) else $error("long block not flagged");

    property p_len_min;
        @(posedge pclk) disable iff (!presetn)
        (blk_wr_valid && blk_wr_len == 16'h0201 && max_rec_code == 4'h8) |=> blk_wr_type_err;
    endproperty
    a_len_min: assert property (p_len_min) else $error("512 byte limit not kept");

    property p_uid_zero;
        @(posedge pclk) disable iff (!presetn)
        !uid_loaded_ff |-> uid_ff == 32'h00000000;
    endproperty
    a_uid_zero: assert property (p_uid_zero) else $error("unique id not zero");

    property p_rd_speed;
        @(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == 8'h20) |=> prdata[2:0] == 3'h2;
    endproperty
    a_rd_speed: assert property (p_rd_speed) else $error("speed read wrong");

    property p_rd_reserved;
        @(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == 8'h20) |=> (prdata[26:24] == 3'h0) && (prdata[11:8] == 4'h0)
                                      && (prdata[5:3] == 3'h0);
    endproperty
    a_rd_reserved: assert property (p_rd_reserved) else $error("reserved read set");

    property p_rd_uid;
        @(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == 8'h24) |=> prdata == $past(uid_ff);
    endproperty
    a_rd_uid: assert property (p_rd_uid) else $error("unique id read wrong");

    // a full load is 64 rom clock edges of 10 cycles each
    property p_rom_load;
        @(posedge pclk) disable iff (!presetn)
        rom_start |-> ##[1:700] load_valid;
    endproperty
    a_rom_load: assert property (p_rom_load) else $error("rom load never finished");
endmodule

// File: tb/testbench.sv
// self-checking testbench for the bus info block registers
`timescale 1ns/1ps
`include "bib_consts.svh"
module testbench;
    import bib_pkg::*;

    // ------------------------------------------
    // signals
    // ------------------------------------------
    logic        pclk;
    logic        presetn;
    logic        soft_resetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        host_bus_reset;
    logic        rom_present;
    logic        rom_data;
    logic        rom_clk;
    logic        rom_changed;
    logic        blk_wr_valid;
    logic [15:0] blk_wr_len;
    logic        blk_wr_type_err;
    logic [3:0]  max_rec_code;
    logic        link_enable_bit;
    int          fail_count;
    int          tests_run;
    logic [31:0] rd;
    // arbitrary rom pattern, vendor field in 31:8
    localparam logic [31:0] ROM_PAT = 32'h5a3ce1a7;

    bib_regs dut_u (
        .pclk(pclk), .presetn(presetn), .soft_resetn(soft_resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_bus_reset(host_bus_reset),
        .rom_present(rom_present), .rom_data(rom_data), .rom_clk(rom_clk),
        .rom_changed(rom_changed), .blk_wr_valid(blk_wr_valid),
        .blk_wr_len(blk_wr_len), .blk_wr_type_err(blk_wr_type_err),
        .max_rec_code(max_rec_code), .link_enable_bit(link_enable_bit)
    );

    // ------------------------------------------
    // helpers
    // ------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // starts on a fresh edge so psel is never assigned twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(q, exp, msg);
    endtask

    task automatic conclude;
        $display("tests_run %0d fail_count %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------
    // scenarios
    // ------------------------------------------
    task automatic t_reset;
        rdchk(8'h20, 32'h0000a002, "options reset");
        rdchk(8'h24, 32'h0, "uid reset");
        check({28'h0, max_rec_code}, 32'ha, "size code reset");
        $display("test reset done");
    endtask

    task automatic t_fields;
        wr(8'h20, 32'hffffffff);
        rdchk(8'h20, 32'hf8fff0c2, "reserved and speed bits");
        check({28'h0, max_rec_code}, 32'hf, "size code written");
        wr(8'h20, 32'h00a5a000);
        rdchk(8'h20, 32'h00a5a002, "accuracy field");
        wr(8'h24, 32'hffffffff);
        rdchk(8'h24, 32'h0, "uid host write");
        wr(8'h30, 32'hffffffff);
        rdchk(8'h30, 32'h0, "unmapped read");
        check({31'h0, pslverr}, 32'h0, "no error response");
        rdchk(8'h20, 32'h00a5a002, "options untouched");
        $display("test fields done");
    endtask

    task automatic t_generation;
        wr(8'h20, 32'h000080c0);
        @(posedge pclk);
        rom_changed <= 1'b1;
        @(posedge pclk);
        rom_changed <= 1'b0;
        // counter is two bits wide, so 3 wraps to 0
        rdchk(8'h20, 32'h00008002, "generation wrap");
        @(posedge pclk);
        rom_changed <= 1'b1;
        @(posedge pclk);
        rom_changed <= 1'b0;
        rdchk(8'h20, 32'h00008042, "generation step");
        $display("test generation done");
    endtask

    task automatic blk(input logic [15:0] len, input logic exp, input string msg);
        @(posedge pclk);
        blk_wr_valid <= 1'b1;
        blk_wr_len   <= len;
        @(posedge pclk);
        blk_wr_valid <= 1'b0;
        #1;
        check({31'h0, blk_wr_type_err}, {31'h0, exp}, msg);
    endtask

    task automatic t_length;
        // code 8 gives 512 bytes, the smallest legal limit
        wr(8'h20, 32'h00008000);
        blk(16'd512, 1'b0, "len at limit");
        blk(16'd513, 1'b1, "len over limit");
        wr(8'h20, 32'h0000a000);
        blk(16'd2048, 1'b0, "len at 2048");
        blk(16'd2049, 1'b1, "len over 2048");
        wr(8'h20, 32'h0000f000);
        blk(16'hffff, 1'b0, "len under 64k");
        $display("test length done");
    endtask

    task automatic t_soft;
        // valid options go in before link enable
        wr(8'h20, 32'h08559000);
        wr(8'h40, 32'h00020000);
        @(posedge pclk);
        check({31'h0, link_enable_bit}, 32'h1, "link enable set");
        @(posedge pclk);
        soft_resetn <= 1'b0;
        repeat (6) @(posedge pclk);
        soft_resetn <= 1'b1;
        repeat (6) @(posedge pclk);
        rdchk(8'h20, 32'h00009002, "soft reset keeps size code");
        check({31'h0, link_enable_bit}, 32'h0, "link enable cleared");
        $display("test soft reset done");
    endtask

    task automatic t_rom;
        int          i;
        logic [31:0] q;
        @(posedge pclk);
        rom_present    <= 1'b1;
        host_bus_reset <= 1'b1;
        rom_data       <= ROM_PAT[31];
        // msb first; a new bit after each falling rom clock
        for (i = 31; i >= 0; i--) begin
            @(posedge rom_clk);
            @(negedge rom_clk);
            @(posedge pclk);
            rom_data <= (i > 0) ? ROM_PAT[i-1] : ~ROM_PAT[0];
        end
        q = 32'h0;
        for (i = 0; i < 100 && q[1] !== 1'b1; i++)
            apb(1'b0, 8'h44, 32'h0, q);
        check({30'h0, q[1:0]}, 32'h3, "rom present and loaded");
        apb(1'b0, 8'h24, 32'h0, q);
        check({8'h0, q[31:8]}, {8'h0, ROM_PAT[31:8]}, "vendor field");
        check({24'h0, q[7:0]}, {24'h0, ROM_PAT[7:0]}, "chip field");
        wr(8'h24, 32'h0);
        rdchk(8'h24, ROM_PAT, "uid locked after load");
        host_bus_reset <= 1'b0;
        $display("test rom load done");
    endtask

    // ------------------------------------------
    // main sequence and timeout
    // ------------------------------------------
    initial begin
        fail_count     = 0;
        tests_run      = 0;
        presetn        = 1'b0;
        soft_resetn    = 1'b1;
        psel           = 1'b0;
        penable        = 1'b0;
        pwrite         = 1'b0;
        paddr          = 8'h0;
        pwdata         = 32'h0;
        pstrb          = 4'hf;
        host_bus_reset = 1'b0;
        rom_present    = 1'b0;
        rom_data       = 1'b0;
        rom_changed    = 1'b0;
        blk_wr_valid   = 1'b0;
        blk_wr_len     = 16'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fields();
        t_generation();
        t_length();
        t_soft();
        t_rom();
        conclude();
    end

    // whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        $display("MISMATCH %0t timeout", $time);
        conclude();
    end
endmodule
